// File: shared/lss_pkg.sv
package lss_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses, 32-bit words)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_FAULT = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h10;
  localparam int WD_BIT = 15;
  // CTRL fields
  localparam int CTRL_ON = 0;
  localparam int CTRL_DIR_DIS = 2;
  localparam int CTRL_PWM_EN = 4;
  localparam int CTRL_VDD_FAIL_EN = 5;
  localparam int CTRL_OVERVOLTAGE_SHUTDOWN_DISABLE = 6;
  localparam int CTRL_W = 7;
  // CFG fields
  localparam int CFG_SLOPE = 0;
  localparam int CFG_STEP_RM = 2;
  localparam int CFG_STEADY = 3;
  localparam int CFG_COOL_EN = 5;
  localparam int CFG_LAMP = 6;
  localparam int CFG_COOL_SLOPE = 7;
  localparam int CFG_W = 9;
  // FAULT fields
  localparam int FLT_OT = 0;
  localparam int FLT_OC = 2;
  localparam int FLT_SC = 4;
  localparam int FLT_OS = 6;
  localparam int FLT_OLOFF = 8;
  localparam int FLT_OLON = 10;
  localparam int FLT_OV = 12;
  localparam int FLT_UV = 13;
  localparam int FLT_POR = 14;
  // STATUS fields
  localparam int ST_NORMAL = 0;
  localparam int ST_FAILSAFE = 1;
  localparam int ST_WD_ARMED = 2;
  localparam int ST_READY = 3;
  localparam int ST_HS = 4;
  localparam int ST_FAULT_N = 6;
  localparam int ST_RETRY0 = 8;
  localparam int ST_RETRY1 = 13;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int READY_TIME_US = 50;
  localparam int READY_CYCLES = READY_TIME_US * CLK_MHZ;
  localparam int RETRY_LIMIT = 16;
  localparam int RETRY_CNT_W = 5;
  localparam int COOL_CNT_W = 8;
  localparam int COOL_SHIFT_BASE = 6;
  localparam logic [1:0] STEP_COLD = 2'h3;

  typedef enum logic [2:0] {
    LSS_SLEEP = 3'b001,
    LSS_NORMAL = 3'b010,
    LSS_FAILSAFE = 3'b100
  } lss_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lss_bus_s;

  typedef struct packed {
    logic [1:0] ot;
    logic [1:0] oc;
    logic [1:0] sc;
    logic [1:0] os;
    logic [1:0] ol_off;
    logic [1:0] ol_on;
    logic ov;
    logic uv;
  } lss_det_s;

  typedef struct packed {
    logic [1:0] overcurrent_slope_sel;
    logic inrush_step_remove;
    logic [1:0] steady_level_sel;
  } lss_ocp_s;
endpackage : lss_pkg

// File: logic/lss_supervisor.sv
`timescale 1ns/1ps
module lss_supervisor #(
  parameter int NCH = 2,
  parameter int WDOG_CYCLES = 250000,
  parameter int RETRY_CYCLES = 125000,
  parameter int COOL_TICK_CYCLES = 25000
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire lss_pkg::lss_bus_s bus,
  output logic [31:0] rdata,
  input wire logic wake_reset_in_n,
  input wire logic wake_in,
  input wire logic [1:0] direct_in,
  input wire logic failsafe_select_input,
  input wire logic vdd_fail,
  input wire logic supply_por,
  input wire logic [1:0] pwm_duty,
  input wire lss_pkg::lss_det_s det,
  output logic [1:0] high_side_outputs,
  output logic fault_status_n,
  output logic normal_mode_flag,
  output logic features_ready,
  output logic [1:0] inrush_apply,
  output logic [3:0] first_inrush_step,
  output lss_pkg::lss_ocp_s ocp
);
  import lss_pkg::*;

  if (NCH != 2) $error("lss_supervisor serves exactly two channels");
  if (WDOG_CYCLES < 2 || WDOG_CYCLES >= (1 << 24)) $error("bad watchdog period");
  if (RETRY_CYCLES < 2 || RETRY_CYCLES >= (1 << 24)) $error("bad retry period");
  if (COOL_TICK_CYCLES < 1 || COOL_TICK_CYCLES >= (1 << 24)) $error("bad cooling tick");

  // ---------------------------------------------------------------
  // Mode control
  // ---------------------------------------------------------------
  lss_mode_e mode_reg, mode_next;
  logic [CTRL_W-1:0] ctrl_reg;
  logic [CFG_W-1:0] cfg_reg;
  logic wd_armed_reg, wd_last_bit_reg, fs_by_wd_reg;
  logic [23:0] wd_cnt_reg;
  logic [3:0] src_prev_reg;
  logic wake, wd_enable, wd_timeout, fail, fs_exit, mode_change, clear_all;
  logic cmd_wr, fault_rd, wd_toggle;
  logic [1:0] fc, hs_cmd, hs_next, fault_ch, retry_fire, fc_rise;
  logic [3:0] src_now;

  assign cmd_wr = bus.wr && (bus.addr == ADDR_CMD);
  assign fault_rd = bus.rd && (bus.addr == ADDR_FAULT);
  assign wake = wake_reset_in_n | wake_in | (|direct_in);
  assign wd_enable = failsafe_select_input;
  assign wd_toggle = cmd_wr && (bus.wdata[WD_BIT] != wd_last_bit_reg);
  assign wd_timeout = wd_armed_reg && (wd_cnt_reg == 24'(WDOG_CYCLES - 1));
  assign fail = (vdd_fail & ctrl_reg[CTRL_VDD_FAIL_EN]) | (wd_timeout & wd_enable);
  assign fs_exit = (~vdd_fail & cmd_wr & bus.wdata[WD_BIT])
                   | (fs_by_wd_reg & ~failsafe_select_input);
  assign src_now = {wake_reset_in_n, wake_in, direct_in};

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      LSS_SLEEP: begin
        if (wake) mode_next = LSS_NORMAL;
      end
      LSS_NORMAL: begin
        if (!wake) mode_next = LSS_SLEEP;
        else if (fail) mode_next = LSS_FAILSAFE;
      end
      LSS_FAILSAFE: begin
        if (!wake) mode_next = LSS_SLEEP;
        else if (fs_exit) mode_next = LSS_NORMAL;
      end
    endcase
  end

  assign mode_change = ((mode_reg == LSS_NORMAL) && (mode_next == LSS_FAILSAFE))
                       || ((mode_reg == LSS_FAILSAFE) && (mode_next == LSS_NORMAL));
  assign clear_all = mode_change | (vdd_fail & ~det.uv) | supply_por;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || supply_por) mode_reg <= LSS_SLEEP;
    else mode_reg <= mode_next;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) fs_by_wd_reg <= 1'b0;
    else if (mode_reg == LSS_NORMAL && mode_next == LSS_FAILSAFE)
      fs_by_wd_reg <= wd_timeout & wd_enable;
    else if (mode_next != LSS_FAILSAFE) fs_by_wd_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) src_prev_reg <= 4'h0;
    else src_prev_reg <= src_now;
  end

  // Armed only by an edge, so a host that never toggles after a quiet start is not punished
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !wd_enable || mode_reg == LSS_SLEEP) wd_armed_reg <= 1'b0;
    else if (|(src_now & ~src_prev_reg)) wd_armed_reg <= 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || mode_next != LSS_NORMAL) wd_last_bit_reg <= 1'b0;
    else if (cmd_wr) wd_last_bit_reg <= bus.wdata[WD_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !wd_armed_reg || mode_reg != LSS_NORMAL || wd_toggle) wd_cnt_reg <= 24'h0;
    else if (!wd_timeout) wd_cnt_reg <= wd_cnt_reg + 24'h1;
  end

  // ---------------------------------------------------------------
  // Start-up readiness
  // ---------------------------------------------------------------
  logic [10:0] ready_cnt_reg;
  logic ready_reg;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || mode_reg == LSS_SLEEP) begin
      ready_cnt_reg <= 11'h0;
      ready_reg <= 1'b0;
    end else if (ready_cnt_reg == 11'(READY_CYCLES - 1)) begin
      ready_reg <= 1'b1;
    end else begin
      ready_cnt_reg <= ready_cnt_reg + 11'h1;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // Outside normal mode software cannot alter the defaults
  always_ff @(posedge sys_clk) begin
    if (!rst_n || supply_por || mode_next != LSS_NORMAL) begin
      ctrl_reg <= '0;
      cfg_reg <= '0;
    end else if (bus.wr && bus.addr == ADDR_CTRL) begin
      ctrl_reg <= bus.wdata[CTRL_W-1:0];
    end else if (bus.wr && bus.addr == ADDR_CFG) begin
      cfg_reg <= bus.wdata[CFG_W-1:0];
    end
  end

  logic pwm_en, ov_shut, cool_active;
  assign pwm_en = ctrl_reg[CTRL_PWM_EN];
  assign ov_shut = det.ov & ~ctrl_reg[CTRL_OVERVOLTAGE_SHUTDOWN_DISABLE];
  assign cool_active = (mode_reg == LSS_NORMAL) && pwm_en && cfg_reg[CFG_COOL_EN]
                       && cfg_reg[CFG_LAMP];

  // ---------------------------------------------------------------
  // Cooling tick
  // ---------------------------------------------------------------
  logic [23:0] tick_cnt_reg;
  logic cool_tick;
  assign cool_tick = (tick_cnt_reg == 24'(COOL_TICK_CYCLES - 1));
  always_ff @(posedge sys_clk) begin
    if (!rst_n || cool_tick) tick_cnt_reg <= 24'h0;
    else tick_cnt_reg <= tick_cnt_reg + 24'h1;
  end

  // ---------------------------------------------------------------
  // Per-channel protection, retry and outputs
  // ---------------------------------------------------------------
  logic [RETRY_CNT_W-1:0] retry_cnt [NCH];
  logic [1:0] oc_lat, ot_lat, sc_lat, uv_lat;

  for (genvar x = 0; x < NCH; x++) begin : g_ch
    logic fc_prev_reg, oc_reg, ot_reg, sc_reg, uv_reg, inrush_reg;
    logic [RETRY_CNT_W-1:0] rcnt_reg;
    logic [23:0] rtimer_reg;
    logic [COOL_CNT_W-1:0] off_cnt_reg;
    logic [1:0] step_reg;
    logic retry_term, can_retry, lat_clr;
    logic [COOL_CNT_W-1:0] scaled;

    assign fc[x] = (direct_in[x] & ~ctrl_reg[CTRL_DIR_DIS + x] & ~pwm_en)
                   | ctrl_reg[CTRL_ON + x];
    always_comb begin
      hs_cmd[x] = 1'b0;
      if (mode_reg == LSS_FAILSAFE) hs_cmd[x] = direct_in[x];
      else if (mode_reg == LSS_NORMAL)
        hs_cmd[x] = (((direct_in[x] & ~ctrl_reg[CTRL_DIR_DIS + x]) | ctrl_reg[CTRL_ON + x])
                    & ~pwm_en) | (ctrl_reg[CTRL_ON + x] & pwm_duty[x] & pwm_en);
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) fc_prev_reg <= 1'b0;
      else fc_prev_reg <= fc[x];
    end
    assign fc_rise[x] = fc[x] & ~fc_prev_reg;

    assign retry_term = oc_reg | ot_reg | uv_reg;
    assign can_retry = retry_term && (rcnt_reg < RETRY_CNT_W'(RETRY_LIMIT));
    assign retry_fire[x] = can_retry && (rtimer_reg == 24'(RETRY_CYCLES - 1));
    assign lat_clr = fc_rise[x] | clear_all;

    // Latches only set while the channel is commanded on; live detection covers the off case
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        oc_reg <= 1'b0;
        ot_reg <= 1'b0;
        sc_reg <= 1'b0;
        uv_reg <= 1'b0;
      end else begin
        oc_reg <= (oc_reg & ~(lat_clr | retry_fire[x])) | (det.oc[x] & hs_cmd[x]);
        ot_reg <= (ot_reg & ~(lat_clr | retry_fire[x])) | (det.ot[x] & hs_cmd[x]);
        sc_reg <= (sc_reg & ~lat_clr) | (det.sc[x] & hs_cmd[x]);
        uv_reg <= (uv_reg & ~(lat_clr | retry_fire[x])) | (det.uv & hs_cmd[x]);
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n || !can_retry || retry_fire[x] || lat_clr) rtimer_reg <= 24'h0;
      else rtimer_reg <= rtimer_reg + 24'h1;
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n || lat_clr) rcnt_reg <= '0;
      else if (retry_fire[x]) rcnt_reg <= rcnt_reg + RETRY_CNT_W'(1);
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) inrush_reg <= 1'b0;
      else inrush_reg <= fc_rise[x] | retry_fire[x];
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n || high_side_outputs[x]) off_cnt_reg <= '0;
      else if (cool_tick && off_cnt_reg != '1) off_cnt_reg <= off_cnt_reg + COOL_CNT_W'(1);
    end

    // Longer off time means a colder filament and a higher first step
    assign scaled = off_cnt_reg >> (COOL_SHIFT_BASE - 32'(cfg_reg[CFG_COOL_SLOPE +: 2]));
    always_ff @(posedge sys_clk) begin
      if (!rst_n || !cool_active) step_reg <= STEP_COLD;
      else if (fc_rise[x]) step_reg <= (scaled > COOL_CNT_W'(STEP_COLD)) ? STEP_COLD
                                       : scaled[1:0];
    end

    assign hs_next[x] = hs_cmd[x] & ~oc_reg & ~ot_reg & ~sc_reg & ~uv_reg & ~det.uv
                        & ~ov_shut;
    assign fault_ch[x] = oc_reg | ot_reg | sc_reg | uv_reg | det.ot[x] | det.os[x]
                         | det.ol_off[x];
    assign retry_cnt[x] = rcnt_reg;
    assign oc_lat[x] = oc_reg;
    assign ot_lat[x] = ot_reg;
    assign sc_lat[x] = sc_reg;
    assign uv_lat[x] = uv_reg;
    assign inrush_apply[x] = inrush_reg;
    assign first_inrush_step[2*x +: 2] = step_reg;
  end

  // ---------------------------------------------------------------
  // Fault flags, clear on read; a new event in the read cycle survives
  // ---------------------------------------------------------------
  logic [1:0] ot_f_reg, oc_f_reg, sc_f_reg, os_f_reg, oloff_f_reg, olon_f_reg;
  logic ov_f_reg, uv_f_reg, por_f_reg;
  logic flag_clr;
  assign flag_clr = fault_rd | clear_all;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ot_f_reg <= 2'h0;
      oc_f_reg <= 2'h0;
      sc_f_reg <= 2'h0;
      os_f_reg <= 2'h0;
      oloff_f_reg <= 2'h0;
      olon_f_reg <= 2'h0;
      ov_f_reg <= 1'b0;
      uv_f_reg <= 1'b0;
    end else begin
      ot_f_reg <= (ot_f_reg & ~{2{flag_clr}}) | det.ot;
      oc_f_reg <= (oc_f_reg & ~{2{flag_clr}}) | oc_lat;
      sc_f_reg <= (sc_f_reg & ~{2{flag_clr}}) | sc_lat;
      os_f_reg <= (os_f_reg & ~{2{fault_rd}}) | det.os;
      oloff_f_reg <= (oloff_f_reg & ~{2{fault_rd}}) | det.ol_off;
      olon_f_reg <= (olon_f_reg & ~{2{fault_rd}}) | det.ol_on;
      ov_f_reg <= (ov_f_reg & ~flag_clr) | det.ov;
      uv_f_reg <= (uv_f_reg & ~flag_clr) | det.uv;
    end
  end

  // Power-on flag survives fail-safe entry, as do the off-state short and openload flags
  always_ff @(posedge sys_clk) begin
    if (!rst_n || supply_por) por_f_reg <= 1'b1;
    else if (fault_rd) por_f_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Pins
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      high_side_outputs <= 2'h0;
      fault_status_n <= 1'b1;
      normal_mode_flag <= 1'b0;
      features_ready <= 1'b0;
      ocp <= '0;
    end else begin
      high_side_outputs <= hs_next;
      fault_status_n <= ~((|fault_ch) | ov_shut | det.uv);
      normal_mode_flag <= (mode_reg == LSS_NORMAL);
      features_ready <= ready_reg;
      ocp <= {cfg_reg[CFG_SLOPE +: 2], cfg_reg[CFG_STEP_RM], cfg_reg[CFG_STEADY +: 2]};
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (bus.addr)
      ADDR_CMD: rd_mux[WD_BIT] = wd_last_bit_reg;
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_reg;
      ADDR_CFG: rd_mux[CFG_W-1:0] = cfg_reg;
      ADDR_FAULT: begin
        rd_mux[FLT_OT +: 2] = ot_f_reg;
        rd_mux[FLT_OC +: 2] = oc_f_reg;
        rd_mux[FLT_SC +: 2] = sc_f_reg;
        rd_mux[FLT_OS +: 2] = os_f_reg;
        rd_mux[FLT_OLOFF +: 2] = oloff_f_reg;
        rd_mux[FLT_OLON +: 2] = olon_f_reg;
        rd_mux[FLT_OV] = ov_f_reg;
        rd_mux[FLT_UV] = uv_f_reg;
        rd_mux[FLT_POR] = por_f_reg;
      end
      ADDR_STATUS: begin
        rd_mux[ST_NORMAL] = normal_mode_flag;
        rd_mux[ST_FAILSAFE] = (mode_reg == LSS_FAILSAFE);
        rd_mux[ST_WD_ARMED] = wd_armed_reg;
        rd_mux[ST_READY] = features_ready;
        rd_mux[ST_HS +: 2] = high_side_outputs;
        rd_mux[ST_FAULT_N] = fault_status_n;
        rd_mux[ST_RETRY0 +: RETRY_CNT_W] = retry_cnt[0];
        rd_mux[ST_RETRY1 +: RETRY_CNT_W] = retry_cnt[1];
      end
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !bus.rd) rdata <= 32'h0;
    else rdata <= rd_mux;
  end
endmodule : lss_supervisor

// File: bench/lss_supervisor_chk.sv
`timescale 1ns/1ps
module lss_supervisor_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire lss_pkg::lss_bus_s bus,
  input wire logic [31:0] rdata,
  input wire logic wake_reset_in_n,
  input wire logic [1:0] direct_in,
  input wire lss_pkg::lss_det_s det,
  input wire logic [1:0] high_side_outputs,
  input wire logic fault_status_n,
  input wire logic normal_mode_flag,
  input wire logic features_ready,
  input wire logic [1:0] inrush_apply
);
  import lss_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------
  // Helper logic
  // ----------------
  logic [11:0] ready_cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ready_cnt <= 12'h0;
    end else if (features_ready) begin
      ready_cnt <= 12'h0;
    end else if (normal_mode_flag) begin
      ready_cnt <= ready_cnt + 12'h1;
    end
  end
  // Only the on-state openload term is live
  sequence s_olon_only;
    det == {10'h0, det.ol_on, 2'h0};
  endsequence
  sequence s_failsafe;
    wake_reset_in_n && !normal_mode_flag && features_ready && det == '0 && $stable(direct_in);
  endsequence
  // ----------------
  // Assertions
  // ----------------
  AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside its slot");
  AST_UV_OFF: assert property (det.uv |=> high_side_outputs == 2'h0)
    else $error("output on during undervoltage");
  AST_UV_FAULT: assert property (det.uv |=> !fault_status_n)
    else $error("fault pin high on undervoltage");
  AST_OS_FAULT: assert property (det.os != 2'h0 |=> !fault_status_n)
    else $error("fault pin high on off-state short");
  AST_OT_FAULT: assert property (det.ot != 2'h0 |=> !fault_status_n)
    else $error("fault pin high on overtemperature");
  AST_OLON_QUIET: assert property (s_olon_only ##1 (s_olon_only and fault_status_n)
    |=> fault_status_n) else $error("on-state openload disturbed fault pin");
  AST_INRUSH_PULSE: assert property (inrush_apply[0] |=> !inrush_apply[0])
    else $error("inrush marker longer than one cycle");
  AST_READY_TIME: assert property ($rose(features_ready) |->
    int'(ready_cnt) inside {[READY_CYCLES - 10:READY_CYCLES + 10]})
    else $error("features ready at wrong time");
  AST_OC_LATCH: assert property (det.oc[0] && high_side_outputs[0] |->
    ##[1:2] (!high_side_outputs[0] && !fault_status_n)) else $error("overcurrent not latched");
  AST_FS_FOLLOW: assert property (s_failsafe [*3] |-> high_side_outputs == direct_in)
    else $error("fail-safe outputs do not follow direct inputs");
endmodule : lss_supervisor_chk

bind lss_supervisor lss_supervisor_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .wake_reset_in_n(wake_reset_in_n), .direct_in(direct_in), .det(det),
  .high_side_outputs(high_side_outputs), .fault_status_n(fault_status_n),
  .normal_mode_flag(normal_mode_flag), .features_ready(features_ready),
  .inrush_apply(inrush_apply)
);

// File: bench/lss_host_model.sv
`timescale 1ns/1ps
module lss_host_model (
  input wire logic sys_clk,
  output lss_pkg::lss_bus_s bus,
  input wire logic [31:0] rdata
);
  import lss_pkg::*;
  logic wd_bit;
  initial begin
    bus = '0;
    wd_bit = 1'b0;
  end
  // ----------------
  // Bus cycles
  // ----------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr
  // Data is taken mid-cycle so the register update has surely landed
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask : rd
  task automatic cmd(input logic b);
    wd_bit = b;
    wr(ADDR_CMD, {16'h0, b, 15'h0});
  endtask : cmd
  task automatic kick;
    cmd(~wd_bit);
  endtask : kick
endmodule : lss_host_model

// File: bench/lss_supervisor_bench.sv
`timescale 1ns/1ps
module lss_supervisor_bench;
  import lss_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wake_reset_in_n = 1'b0, wake_in = 1'b0, failsafe_select_input = 1'b0;
  logic vdd_fail = 1'b0, supply_por = 1'b0;
  logic [1:0] direct_in = 2'h0, pwm_duty = 2'h0, high_side_outputs, inrush_apply;
  lss_det_s det = '0;
  lss_bus_s bus;
  lss_ocp_s ocp;
  logic [31:0] rdata, rv;
  logic [3:0] first_inrush_step;
  logic fault_status_n, normal_mode_flag, features_ready;
  int n_fail = 0, total_checks = 0, n_pulse = 0;
  always #20 sys_clk = ~sys_clk;
  // Counted mid-cycle to stay clear of the edge that updates it
  always @(negedge sys_clk) if (inrush_apply[0] === 1'b1) n_pulse++;
  lss_supervisor #(.WDOG_CYCLES(20), .RETRY_CYCLES(20), .COOL_TICK_CYCLES(2)) u_lss_supervisor (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .wake_reset_in_n(wake_reset_in_n), .wake_in(wake_in), .direct_in(direct_in),
    .failsafe_select_input(failsafe_select_input), .vdd_fail(vdd_fail),
    .supply_por(supply_por), .pwm_duty(pwm_duty), .det(det),
    .high_side_outputs(high_side_outputs), .fault_status_n(fault_status_n),
    .normal_mode_flag(normal_mode_flag), .features_ready(features_ready),
    .inrush_apply(inrush_apply), .first_inrush_step(first_inrush_step), .ocp(ocp));
  lss_host_model u_lss_host_model (.sys_clk(sys_clk), .bus(bus), .rdata(rdata));
  // ----------------
  // Helpers
  // ----------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    u_lss_host_model.rd(a, rv);
    chk(rv, e);
  endtask : rd_chk
  task automatic set_dir(input logic [1:0] v);
    @(posedge sys_clk);
    direct_in <= v;
    tick(3);
  endtask : set_dir
  task automatic pulse_det(input lss_det_s d);
    @(posedge sys_clk);
    det <= d;
    @(posedge sys_clk);
    det <= '0;
  endtask : pulse_det
  task automatic print_verdict;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_startup;
    int n;
    @(posedge sys_clk);
    wake_reset_in_n <= 1'b1;
    n = 0;
    while (features_ready !== 1'b1 && n < 1400) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(n >= 1245 && n <= 1256), 32'h1);
    chk(normal_mode_flag, 32'h1);
    rd_chk(ADDR_FAULT, 32'h4000);
    rd_chk(ADDR_FAULT, 32'h0);
    rd_chk(5'h1c, 32'h0);
    u_lss_host_model.cmd(1'b1);
  endtask : t_startup
  task automatic t_watchdog;
    @(posedge sys_clk);
    failsafe_select_input <= 1'b1;
    wake_in <= 1'b1;
    repeat (3) begin
      tick(12);
      u_lss_host_model.kick();
    end
    chk(normal_mode_flag, 32'h1);
    tick(30);
    chk(normal_mode_flag, 32'h0);
    set_dir(2'h2);
    chk(high_side_outputs, 32'h2);
    u_lss_host_model.wr(ADDR_CTRL, 32'h1);
    rd_chk(ADDR_CTRL, 32'h0);
    u_lss_host_model.cmd(1'b1);
    tick(3);
    chk(normal_mode_flag, 32'h1);
    tick(30);
    chk(normal_mode_flag, 32'h0);
    @(posedge sys_clk);
    failsafe_select_input <= 1'b0;
    tick(3);
    chk(normal_mode_flag, 32'h1);
    tick(30);
    chk(normal_mode_flag, 32'h1);
  endtask : t_watchdog
  task automatic t_oc;
    n_pulse = 0;
    set_dir(2'h1);
    chk(n_pulse, 32'h1);
    chk(high_side_outputs, 32'h1);
    @(posedge sys_clk);
    det <= 14'h400;
    tick(4);
    n_pulse = 0;
    chk(fault_status_n, 32'h0);
    rd_chk(ADDR_FAULT, 32'h4);
    tick(500);
    chk(n_pulse, 32'h10);
    u_lss_host_model.rd(ADDR_STATUS, rv);
    chk(rv & 32'h1f00, 32'h1000);
    @(posedge sys_clk);
    det <= '0;
    tick(5);
    chk(fault_status_n, 32'h0);
    set_dir(2'h0);
    set_dir(2'h1);
    chk(high_side_outputs, 32'h1);
    chk(fault_status_n, 32'h1);
    rd_chk(ADDR_FAULT, 32'h4);
  endtask : t_oc
  task automatic t_sc;
    @(posedge sys_clk);
    n_pulse = 0;
    pulse_det(14'h100);
    tick(60);
    chk(n_pulse, 32'h0);
    chk(high_side_outputs, 32'h0);
    chk(fault_status_n, 32'h0);
    rd_chk(ADDR_FAULT, 32'h10);
    set_dir(2'h0);
    set_dir(2'h1);
    chk(high_side_outputs, 32'h1);
    rd_chk(ADDR_FAULT, 32'h10);
  endtask : t_sc
  task automatic t_ov;
    @(posedge sys_clk);
    det <= 14'h2;
    tick(3);
    chk(high_side_outputs, 32'h0);
    chk(fault_status_n, 32'h0);
    det <= '0;
    tick(3);
    chk(high_side_outputs, 32'h1);
    u_lss_host_model.wr(ADDR_CTRL, 32'h40);
    det <= 14'h2;
    tick(3);
    chk(high_side_outputs, 32'h1);
    chk(fault_status_n, 32'h1);
    det <= '0;
    rd_chk(ADDR_FAULT, 32'h1000);
    u_lss_host_model.wr(ADDR_CTRL, 32'h0);
  endtask : t_ov
  task automatic t_uv;
    set_dir(2'h0);
    pulse_det(14'h1);
    tick(3);
    chk(fault_status_n, 32'h1);
    rd_chk(ADDR_FAULT, 32'h2000);
    set_dir(2'h1);
    pulse_det(14'h1);
    tick(3);
    chk(fault_status_n, 32'h0);
    tick(30);
    chk(high_side_outputs, 32'h1);
    rd_chk(ADDR_FAULT, 32'h2000);
  endtask : t_uv
  task automatic t_olon;
    @(posedge sys_clk);
    det <= 14'h4;
    tick(4);
    chk(high_side_outputs, 32'h1);
    chk(fault_status_n, 32'h1);
    pulse_det(14'h40);
    pulse_det(14'h2000);
    tick(3);
    chk(fault_status_n, 32'h1);
    rd_chk(ADDR_FAULT, 32'h442);
  endtask : t_olon
  task automatic t_vdd;
    pulse_det(14'h400);
    tick(2);
    chk(high_side_outputs, 32'h0);
    u_lss_host_model.wr(ADDR_CTRL, 32'h20);
    vdd_fail <= 1'b1;
    tick(4);
    chk(normal_mode_flag, 32'h0);
    chk(high_side_outputs, 32'h1);
    u_lss_host_model.cmd(1'b1);
    tick(3);
    chk(normal_mode_flag, 32'h0);
    vdd_fail <= 1'b0;
    u_lss_host_model.cmd(1'b1);
    tick(3);
    chk(normal_mode_flag, 32'h1);
    u_lss_host_model.wr(ADDR_CFG, 32'h1a);
    tick(2);
    chk(ocp, 32'h13);
    chk(first_inrush_step[1:0], 32'h3);
  endtask : t_vdd
  task automatic t_pwm;
    u_lss_host_model.wr(ADDR_CFG, 32'h1e0);
    u_lss_host_model.wr(ADDR_CTRL, 32'h10);
    tick(20);
    u_lss_host_model.wr(ADDR_CTRL, 32'h11);
    tick(2);
    chk(first_inrush_step, 32'hd);
    pwm_duty <= 2'h1;
    tick(3);
    chk(high_side_outputs, 32'h1);
    pulse_det(14'h410);
    tick(2);
    chk(high_side_outputs, 32'h0);
    rd_chk(ADDR_FAULT, 32'h104);
    @(posedge sys_clk);
    supply_por <= 1'b1;
    tick(2);
    supply_por <= 1'b0;
    tick(3);
    chk(high_side_outputs, 32'h1);
    chk(fault_status_n, 32'h1);
    rd_chk(ADDR_FAULT, 32'h4000);
  endtask : t_pwm
  initial begin
    tick(4);
    rst_n <= 1'b1;
    t_startup;
    t_watchdog;
    t_oc;
    t_sc;
    t_ov;
    t_uv;
    t_olon;
    t_vdd;
    t_pwm;
    print_verdict;
  end
  initial begin
    tick(12000);
    n_fail++;
    print_verdict;
  end
endmodule : lss_supervisor_bench
